// *** rtl/gdp_protect_regs.sv ***
// Purpose: protection setup bank of an isolated gate driver, reached by 24-bit serial frames
// Assumes: serial clock is its own domain; cs_n_i stays high at least 8 core cycles between frames
// Notes: a frame takes effect at the chip-select rising edge, after its crc has been checked
// Function
// - the undervoltage and overcurrent register lives at 0x02 in frames of flag, address, ten data bits and crc.
// - a 3-bit undervoltage threshold code picks 10.0 V to 13.5 V in 0.5 V steps and resets to code 3.
// - a 3-bit overcurrent threshold code picks 0.25 V to 2.00 V in 0.25 V steps and resets to code 3.
// - a 3-bit overcurrent filter code picks 0.5 us to 4.0 us in 0.5 us steps and resets to code 3.
// - in non-latching mode switching stops only while undervoltage lasts and the irq pin tracks it.
// - in latching mode undervoltage holds switching off until software clears the latched fault.
// - in latching mode the irq pin follows the latched fault rather than the live condition.
// - the short-circuit register lives at 0x03 with 4-bit level, 3-bit limit and 3-bit filter, reset 3, 2, 4.
// - the 4-bit field picks the two-step turn-off voltage and the 3-bit field the short-circuit level.
// - the short-circuit filter time comes from its code and the fast filter bit, which shortens it.
// - filter codes give 400 ns to 1100 ns in 100 ns steps, or 100 ns to 800 ns with fast filter set.
// - locked fields take writes only in configuration mode, the gate stays off there, and exit stores a crc.
`timescale 1ns/1ps
module gdp_protect_regs #(
   parameter int CLK_PERIOD_NS = gdp_pkg::CLK_PERIOD_NS
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   input wire logic gate_supply_low_i,
   input wire logic fault_clear_i,
   output logic gate_block_o,
   output logic irq_pin_b_n_o,
   output logic gate_supply_low_fault_o,
   output logic config_active_o,
   output logic fast_short_filter_o,
   output logic frame_error_o,
   output logic [7:0] config_crc_o,
   output logic [13:0] gate_supply_low_limit_mv_o,
   output logic [11:0] overcurrent_limit_mv_o,
   output logic [7:0] overcurrent_filter_cycles_o,
   output logic [10:0] two_step_off_level_10mv_o,
   output logic [11:0] short_circuit_limit_mv_o,
   output logic [7:0] short_circuit_filter_cycles_o
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   // the short-circuit filter step must be a whole number of cycles and the longest overcurrent filter must fit eight bits
   if ((gdp_pkg::SCF_STEP_NS % CLK_PERIOD_NS) != 0) begin : g_bad_period
      $error("clock period does not divide the filter step");
   end
   if (((gdp_pkg::OCF_BASE_NS + 7 * gdp_pkg::OCF_STEP_NS) / CLK_PERIOD_NS) > 255) begin : g_bad_range
      $error("clock period too short for the filter counts");
   end

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [23:0] rx_word;
   logic [4:0] rx_bits;
   logic [1:0] pin_sync;
   logic cs_n_s;
   logic uv_now;
   logic cs_prev;
   logic frame_end;
   gdp_pkg::gdp_frame_t frame_q;
   logic [4:0] frame_bits_q;
   logic frame_pend;
   logic resp_pend;
   logic frame_ok;
   logic frame_wr;
   logic cfg_open;
   logic exit_cfg;
   gdp_pkg::gdp_oc_uv_t oc_uv;
   gdp_pkg::gdp_sc_t sc;
   logic [9:0] mode_word_two;
   logic [9:0] next_mode;
   logic [4:0] resp_addr;
   logic [9:0] read_data;
   logic [23:0] resp_word;
   logic uv_fault;
   logic irq_level;
   logic block_now;
   int scf_ns;

   // ****************************************************************
   // link domain and crossings
   // ****************************************************************
   gdp_spi_link u_link (
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .mosi_i(mosi_i),
      .resp_i(resp_word),
      .miso_o(miso_o),
      .rx_word_o(rx_word),
      .rx_bits_o(rx_bits)
   );

   gdp_sync #(
      .WIDTH(2),
      .RESET_VAL(2'h2)
   ) u_pin_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .d_i({cs_n_i, gate_supply_low_i}),
      .q_o(pin_sync)
   );

   assign cs_n_s = pin_sync[1];
   assign uv_now = pin_sync[0];

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cs_prev <= 1'b1;
      end else begin
         cs_prev <= cs_n_s;
      end
   end

   assign frame_end = cs_n_s & ~cs_prev;

   // the link word is frozen once sclk has stopped, so the synchronised cs edge qualifies it
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         frame_q <= '0;
         frame_bits_q <= 5'h00;
         frame_pend <= 1'b0;
      end else begin
         frame_pend <= frame_end;
         if (frame_end) begin
            frame_q <= rx_word;
            frame_bits_q <= rx_bits;
         end
      end
   end

   // ****************************************************************
   // frame check and decode
   // ****************************************************************
   // a frame counts only with exactly 24 bits and a matching crc over bits 23 to 8
   always_comb begin
      frame_ok = frame_pend && (frame_bits_q == 5'(gdp_pkg::FRAME_BITS)) &&
                 (gdp_pkg::crc8_step(gdp_pkg::CRC_INIT, frame_q[23:8]) == frame_q.crc);
      frame_wr = frame_ok && frame_q.read_write_flag;
      cfg_open = mode_word_two[gdp_pkg::MODE_CFG_EN_POS];
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         frame_error_o <= 1'b0;
      end else if (frame_pend) begin
         frame_error_o <= ~frame_ok;
      end
   end

   // ****************************************************************
   // mode word: configuration enable and fast filter
   // ****************************************************************
   // the enable bit is always writable; the fast filter bit only while configuration is open
   always_comb begin
      next_mode = mode_word_two;
      if (frame_wr && (frame_q.addr == gdp_pkg::ADDR_MODE_TWO)) begin
         next_mode[gdp_pkg::MODE_CFG_EN_POS] = frame_q.data[gdp_pkg::MODE_CFG_EN_POS];
         if (cfg_open) begin
            next_mode[gdp_pkg::MODE_FAST_POS] = frame_q.data[gdp_pkg::MODE_FAST_POS];
         end
      end
      exit_cfg = cfg_open && !next_mode[gdp_pkg::MODE_CFG_EN_POS];
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mode_word_two <= gdp_pkg::MODE_RESET;
      end else begin
         mode_word_two <= next_mode;
      end
   end

   // ****************************************************************
   // protection setup registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         oc_uv <= gdp_pkg::OC_UV_RESET;
      end else if (frame_wr && cfg_open && (frame_q.addr == gdp_pkg::ADDR_OC_UV)) begin
         oc_uv <= frame_q.data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sc <= gdp_pkg::SC_RESET;
      end else if (frame_wr && cfg_open && (frame_q.addr == gdp_pkg::ADDR_SC)) begin
         sc <= frame_q.data;
      end
   end

   // crc of the configured registers is taken on the frame that leaves configuration mode
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         config_crc_o <= 8'h00;
      end else if (frame_wr && (frame_q.addr == gdp_pkg::ADDR_MODE_TWO) && exit_cfg) begin
         config_crc_o <= gdp_pkg::crc8_step(gdp_pkg::crc8_step(gdp_pkg::CRC_INIT, {6'h00, oc_uv}),
                                            {6'h00, sc});
      end
   end

   // ****************************************************************
   // read-back response
   // ****************************************************************
   // built one cycle after the frame so a write is echoed with its stored result
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         resp_pend <= 1'b0;
         resp_addr <= 5'h00;
      end else begin
         resp_pend <= frame_ok;
         if (frame_ok) begin
            resp_addr <= frame_q.addr;
         end
      end
   end

   always_comb begin
      unique case (resp_addr)
         gdp_pkg::ADDR_MODE_TWO: read_data = mode_word_two;
         gdp_pkg::ADDR_OC_UV: read_data = oc_uv;
         gdp_pkg::ADDR_SC: read_data = sc;
         default: read_data = 10'h000;
      endcase
   end

   // resp_word changes only in the cs-high gap, so the link sees it quasi-static during a frame
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         resp_word <= '0;
      end else if (resp_pend) begin
         resp_word <= {1'b0, resp_addr, read_data,
                       gdp_pkg::crc8_step(gdp_pkg::CRC_INIT, {1'b0, resp_addr, read_data})};
      end
   end

   // ****************************************************************
   // undervoltage handling and gate blocking
   // ****************************************************************
   // the sticky fault latches in both modes; a new undervoltage beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         uv_fault <= 1'b0;
      end else if (uv_now) begin
         uv_fault <= 1'b1;
      end else if (fault_clear_i) begin
         uv_fault <= 1'b0;
      end
   end

   always_comb begin
      if (oc_uv.undervolt_hold_mode) begin
         irq_level = uv_fault;
         block_now = uv_now | uv_fault;
      end else begin
         irq_level = uv_now;
         block_now = uv_now;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         gate_block_o <= 1'b1;
         irq_pin_b_n_o <= 1'b1;
         gate_supply_low_fault_o <= 1'b0;
         config_active_o <= 1'b0;
      end else begin
         gate_block_o <= block_now | cfg_open;
         irq_pin_b_n_o <= ~irq_level;
         gate_supply_low_fault_o <= uv_fault;
         config_active_o <= cfg_open;
      end
   end

   // ****************************************************************
   // decoded settings for the analog side
   // ****************************************************************
   // fast filter removes a fixed time from the short-circuit filter time of every code
   always_comb begin
      scf_ns = gdp_pkg::SCF_BASE_NS + gdp_pkg::SCF_STEP_NS * int'(sc.short_circuit_filter_code);
      if (mode_word_two[gdp_pkg::MODE_FAST_POS]) begin
         scf_ns = scf_ns - gdp_pkg::SCF_FAST_NS;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         gate_supply_low_limit_mv_o <= 14'h0000;
         overcurrent_limit_mv_o <= 12'h000;
         overcurrent_filter_cycles_o <= 8'h00;
         two_step_off_level_10mv_o <= 11'h000;
         short_circuit_limit_mv_o <= 12'h000;
         short_circuit_filter_cycles_o <= 8'h00;
         fast_short_filter_o <= 1'b0;
      end else begin
         gate_supply_low_limit_mv_o <= 14'(gdp_pkg::UV_BASE_MV +
                                           gdp_pkg::UV_STEP_MV * int'(oc_uv.gate_supply_low_limit));
         overcurrent_limit_mv_o <= 12'(gdp_pkg::OC_BASE_MV +
                                       gdp_pkg::OC_STEP_MV * int'(oc_uv.overcurrent_limit));
         overcurrent_filter_cycles_o <= 8'((gdp_pkg::OCF_BASE_NS + gdp_pkg::OCF_STEP_NS *
                                            int'(oc_uv.overcurrent_filter_time)) / CLK_PERIOD_NS);
         two_step_off_level_10mv_o <= gdp_pkg::TWO_STEP_10MV[sc.two_step_off_level];
         short_circuit_limit_mv_o <= gdp_pkg::SC_LIMIT_MV[sc.short_circuit_limit];
         short_circuit_filter_cycles_o <= 8'(scf_ns / CLK_PERIOD_NS);
         fast_short_filter_o <= mode_word_two[gdp_pkg::MODE_FAST_POS];
      end
   end

endmodule

// *** rtl/gdp_pkg.sv ***
// Purpose: shared constants, types and crc helper for the protection setup bank
// Assumes: 24-bit serial frames, 50 MHz core clock
// Notes: filter times are turned into core clock cycles in the bank itself
package gdp_pkg;

   // ****************************************************************
   // frame layout and addresses
   // ****************************************************************
   localparam int FRAME_BITS = 24;
   localparam logic [4:0] ADDR_MODE_TWO = 5'h01;
   localparam logic [4:0] ADDR_OC_UV = 5'h02;
   localparam logic [4:0] ADDR_SC = 5'h03;
   localparam logic [7:0] CRC_POLY = 8'h2f;
   localparam logic [7:0] CRC_INIT = 8'hff;

   typedef struct packed {
      logic read_write_flag;
      logic [4:0] addr;
      logic [9:0] data;
      logic [7:0] crc;
   } gdp_frame_t;

   typedef struct packed {
      logic undervolt_hold_mode;
      logic [2:0] gate_supply_low_limit;
      logic [2:0] overcurrent_limit;
      logic [2:0] overcurrent_filter_time;
   } gdp_oc_uv_t;

   typedef struct packed {
      logic [3:0] two_step_off_level;
      logic [2:0] short_circuit_limit;
      logic [2:0] short_circuit_filter_code;
   } gdp_sc_t;

   // ****************************************************************
   // reset values and mode word fields
   // ****************************************************************
   localparam gdp_oc_uv_t OC_UV_RESET = 10'h0db;
   localparam gdp_sc_t SC_RESET = 10'h0d4;
   localparam logic [9:0] MODE_RESET = 10'h200;
   localparam int MODE_FAST_POS = 9;
   localparam int MODE_CFG_EN_POS = 2;

   // ****************************************************************
   // analog ranges and timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int UV_BASE_MV = 10000;
   localparam int UV_STEP_MV = 500;
   localparam int OC_BASE_MV = 250;
   localparam int OC_STEP_MV = 250;
   localparam int OCF_BASE_NS = 500;
   localparam int OCF_STEP_NS = 500;
   localparam int SCF_BASE_NS = 400;
   localparam int SCF_STEP_NS = 100;
   localparam int SCF_FAST_NS = 300;
   localparam logic [11:0] SC_LIMIT_MV [0:7] = '{12'h1f4, 12'h2ee, 12'h3e8, 12'h4e2,
                                                12'h5dc, 12'h7d0, 12'h9c4, 12'hbb8};
   // two-step off level in units of 10 mV
   localparam logic [10:0] TWO_STEP_10MV [0:15] = '{11'h288, 11'h29b, 11'h2af, 11'h2c4,
                                                    11'h2dc, 11'h2f4, 11'h30f, 11'h32d,
                                                    11'h34e, 11'h371, 11'h397, 11'h3c2,
                                                    11'h3f1, 11'h426, 11'h461, 11'h4a4};

   // msb-first crc over one 16-bit word
   function automatic logic [7:0] crc8_step(input logic [7:0] crc_in, input logic [15:0] data);
      logic [7:0] c;
      c = crc_in;
      for (int i = 15; i >= 0; i--) begin
         if (c[7] ^ data[i]) begin
            c = {c[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

endpackage

// *** rtl/gdp_sync.sv ***
// Purpose: two-flop level synchroniser into the core clock
// Assumes: inputs are levels that stay put for several core cycles
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module gdp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         meta <= RESET_VAL;
         q_o <= RESET_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

// *** rtl/gdp_spi_link.sv ***
// Purpose: serial-clock side of the 24-bit frame port
// Assumes: mode 0 framing, sclk idles low and runs only while cs_n_i is low
// Notes: word and bit count stay frozen once sclk stops, the core samples them after cs rises
`timescale 1ns/1ps
module gdp_spi_link (
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   input wire logic [23:0] resp_i,
   output logic miso_o,
   output logic [23:0] rx_word_o,
   output logic [4:0] rx_bits_o
);
   logic armed;

   // armed is preset while the chip is deselected, so the first edge of a frame restarts the count
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         armed <= 1'b1;
      end else begin
         armed <= 1'b0;
      end
   end

   always_ff @(posedge sclk_i) begin
      rx_word_o <= {rx_word_o[22:0], mosi_i};
      if (armed) begin
         rx_bits_o <= 5'h01;
      end else if (rx_bits_o != 5'h1f) begin
         rx_bits_o <= rx_bits_o + 5'h01;
      end
   end

   // response msb is always zero, so the idle level already presents it
   always_ff @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         miso_o <= 1'b0;
      end else if (rx_bits_o < 5'h18) begin
         miso_o <= resp_i[5'h17 - rx_bits_o];
      end else begin
         miso_o <= 1'b0;
      end
   end
endmodule

// *** bench/gdp_protect_monitor.sv ***
// Purpose: port-level checks on the protection setup bank
// Assumes: every watched output sits in the core clock domain
// Notes: bound to gdp_protect_regs at the foot of this file
`timescale 1ns/1ps
module gdp_protect_monitor #(
   parameter int CLK_PERIOD_NS = 20
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic gate_supply_low_i,
   input wire logic fault_clear_i,
   input wire logic gate_block_o,
   input wire logic irq_pin_b_n_o,
   input wire logic gate_supply_low_fault_o,
   input wire logic config_active_o,
   input wire logic fast_short_filter_o,
   input wire logic [13:0] gate_supply_low_limit_mv_o,
   input wire logic [11:0] overcurrent_limit_mv_o,
   input wire logic [7:0] short_circuit_filter_cycles_o
);
   logic [3:0] rst_age;
   logic [3:0] uv_quiet;
   int scf_ns;

   // saturating ages keep $past away from values held in reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rst_age <= 4'h0;
      end else if (rst_age != 4'hf) begin
         rst_age <= rst_age + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i || gate_supply_low_i) begin
         uv_quiet <= 4'h0;
      end else if (uv_quiet != 4'hf) begin
         uv_quiet <= uv_quiet + 4'h1;
      end
   end

   assign scf_ns = int'(short_circuit_filter_cycles_o) * CLK_PERIOD_NS + (fast_short_filter_o ? 300 : 0);

   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_cfg_blocks_gate: assert property (config_active_o && $past(config_active_o) |-> gate_block_o)
      else $error("gate not blocked in config mode");
   a_uv_blocks_gate: assert property (rst_age > 4'h6 && $past(gate_supply_low_i, 3) &&
      $past(gate_supply_low_i, 4) |-> gate_block_o)
      else $error("gate not blocked on undervoltage");
   a_irq_blocks_gate: assert property (!irq_pin_b_n_o |-> gate_block_o)
      else $error("irq low while gate enabled");
   a_irq_has_fault: assert property (!irq_pin_b_n_o && !$past(irq_pin_b_n_o) |-> gate_supply_low_fault_o)
      else $error("irq low without undervoltage fault");
   a_fault_sticky: assert property (gate_supply_low_fault_o && !$past(fault_clear_i) |=> gate_supply_low_fault_o)
      else $error("undervoltage fault dropped without clear");
   a_fault_clears: assert property (uv_quiet > 4'h4 && fault_clear_i |-> ##2 !gate_supply_low_fault_o)
      else $error("undervoltage fault not cleared");
   a_uv_limit_step: assert property (rst_age > 4'h2 |-> gate_supply_low_limit_mv_o >= 10000 &&
      gate_supply_low_limit_mv_o <= 13500 && gate_supply_low_limit_mv_o % 500 == 0)
      else $error("undervoltage limit off grid");
   a_oc_limit_step: assert property (rst_age > 4'h2 |-> overcurrent_limit_mv_o >= 250 &&
      overcurrent_limit_mv_o <= 2000 && overcurrent_limit_mv_o % 250 == 0)
      else $error("overcurrent limit off grid");
   a_short_filter_span: assert property (rst_age > 4'h4 &&
      fast_short_filter_o == $past(fast_short_filter_o) && fast_short_filter_o == $past(fast_short_filter_o, 3)
      |-> scf_ns >= 400 && scf_ns <= 1100 && scf_ns % 100 == 0)
      else $error("short filter time off grid");
endmodule

bind gdp_protect_regs gdp_protect_monitor #(.CLK_PERIOD_NS(CLK_PERIOD_NS)) mon (.clk_i(clk_i),
   .resetn_i(resetn_i), .gate_supply_low_i(gate_supply_low_i), .fault_clear_i(fault_clear_i),
   .gate_block_o(gate_block_o), .irq_pin_b_n_o(irq_pin_b_n_o), .gate_supply_low_fault_o(gate_supply_low_fault_o),
   .config_active_o(config_active_o), .fast_short_filter_o(fast_short_filter_o),
   .gate_supply_low_limit_mv_o(gate_supply_low_limit_mv_o), .overcurrent_limit_mv_o(overcurrent_limit_mv_o),
   .short_circuit_filter_cycles_o(short_circuit_filter_cycles_o));

// *** bench/gdp_spi_host.sv ***
// Purpose: serial host that frames 24-bit transfers into the bank
// Assumes: mode 0, 48 ns serial period, clock still between frames
// Notes: mosi is inverted after release so a stale bit never looks valid
`timescale 1ns/1ps
module gdp_spi_host (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   // cs rises once after time zero so the link's asynchronous preset sees a real edge
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b0;
      mosi_o = 1'b0;
      #1 cs_n_o = 1'b1;
   end

   function automatic logic [7:0] crc8(input logic [7:0] c_in, input logic [15:0] d);
      logic [7:0] c;
      c = c_in;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? gdp_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   // bad flips the crc's low bit to provoke a refusal
   task automatic send(input logic wr, input logic [4:0] a, input logic [9:0] d, input logic bad,
                       output logic [23:0] r);
      logic [23:0] w;
      w = {wr, a, d, crc8(gdp_pkg::CRC_INIT, {wr, a, d}) ^ {7'h00, bad}};
      cs_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi_o = w[i];
         #24 sclk_o = 1'b1;
         r[i] = miso_i;
         #24 sclk_o = 1'b0;
      end
      #24 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #200;
   endtask
endmodule

// *** bench/test_gdp_protect_regs.sv ***
// Purpose: self-checking bench for the protection setup bank
// Assumes: frames come from the serial host model
// Notes: a read answer arrives during the following frame
`timescale 1ns/1ps
module test_gdp_protect_regs;
   logic clk_i, resetn_i, sclk_i, cs_n_i, mosi_i, miso_o, gate_supply_low_i, fault_clear_i;
   logic gate_block_o, irq_pin_b_n_o, gate_supply_low_fault_o, config_active_o, fast_short_filter_o;
   logic frame_error_o;
   logic [7:0] config_crc_o, overcurrent_filter_cycles_o, short_circuit_filter_cycles_o;
   logic [13:0] gate_supply_low_limit_mv_o;
   logic [11:0] overcurrent_limit_mv_o, short_circuit_limit_mv_o;
   logic [10:0] two_step_off_level_10mv_o;
   logic [9:0] d, a2, a3;
   logic [23:0] r;
   int n_mismatch, samples_checked, cycles;

   gdp_spi_host host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i), .miso_i(miso_o));

   gdp_protect_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
      .mosi_i(mosi_i), .miso_o(miso_o), .gate_supply_low_i(gate_supply_low_i), .fault_clear_i(fault_clear_i),
      .gate_block_o(gate_block_o), .irq_pin_b_n_o(irq_pin_b_n_o), .gate_supply_low_fault_o(gate_supply_low_fault_o),
      .config_active_o(config_active_o), .fast_short_filter_o(fast_short_filter_o),
      .frame_error_o(frame_error_o), .config_crc_o(config_crc_o),
      .gate_supply_low_limit_mv_o(gate_supply_low_limit_mv_o), .overcurrent_limit_mv_o(overcurrent_limit_mv_o),
      .overcurrent_filter_cycles_o(overcurrent_filter_cycles_o),
      .two_step_off_level_10mv_o(two_step_off_level_10mv_o), .short_circuit_limit_mv_o(short_circuit_limit_mv_o),
      .short_circuit_filter_cycles_o(short_circuit_filter_cycles_o));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask

   // ten core cycles cover the sync and update path after cs rises
   task automatic wr(input logic [4:0] a, input logic [9:0] v);
      host.send(1'b1, a, v, 1'b0, r);
      tick(10);
   endtask

   task automatic rd(input logic [4:0] a, output logic [9:0] v);
      host.send(1'b0, a, 10'h000, 1'b0, r);
      tick(10);
      host.send(1'b0, a, 10'h000, 1'b0, r);
      tick(10);
      v = r[17:8];
      check(r[23:18], {1'b0, a});
      check(r[7:0], host.crc8(gdp_pkg::CRC_INIT, r[23:8]));
   endtask

   task automatic chk_dec(input logic [9:0] r2, input logic [9:0] r3, input logic f);
      check(gate_supply_low_limit_mv_o, 10000 + 500 * r2[8:6]);
      check(overcurrent_limit_mv_o, 250 + 250 * r2[5:3]);
      check(overcurrent_filter_cycles_o, (500 + 500 * r2[2:0]) / gdp_pkg::CLK_PERIOD_NS);
      check(two_step_off_level_10mv_o, gdp_pkg::TWO_STEP_10MV[r3[9:6]]);
      check(short_circuit_limit_mv_o, gdp_pkg::SC_LIMIT_MV[r3[5:3]]);
      check(short_circuit_filter_cycles_o, (400 + 100 * r3[2:0] - 300 * f) / gdp_pkg::CLK_PERIOD_NS);
      check(fast_short_filter_o, f);
   endtask

   task automatic uv_case(input logic latch);
      gate_supply_low_i = 1'b1;
      tick(6);
      check(gate_block_o, 1'b1);
      check(irq_pin_b_n_o, 1'b0);
      gate_supply_low_i = 1'b0;
      tick(6);
      check(gate_block_o, latch);
      check(irq_pin_b_n_o, !latch);
      check(gate_supply_low_fault_o, 1'b1);
      fault_clear_i = 1'b1;
      tick(1);
      fault_clear_i = 1'b0;
      tick(4);
      check(gate_supply_low_fault_o, 1'b0);
      check(gate_block_o, 1'b0);
      check(irq_pin_b_n_o, 1'b1);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // the whole sequence needs well under 10000 core cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      resetn_i = 1'b0;
      gate_supply_low_i = 1'b0;
      fault_clear_i = 1'b0;
      n_mismatch = 0;
      samples_checked = 0;
      cycles = 0;
      tick(2);
      resetn_i = 1'b1;
      tick(4);
      check(config_active_o, 1'b0);
      check(gate_block_o, 1'b0);
      chk_dec(10'h0db, 10'h0d4, 1'b1);
      rd(5'h02, d);
      check(d, 10'h0db);
      rd(5'h03, d);
      check(d, 10'h0d4);
      wr(5'h02, 10'h155);
      wr(5'h01, 10'h000);
      rd(5'h02, d);
      check(d, 10'h0db);
      check(fast_short_filter_o, 1'b1);
      uv_case(1'b0);
      wr(5'h01, 10'h204);
      check(config_active_o, 1'b1);
      check(gate_block_o, 1'b1);
      for (int f = 0; f < 2; f++) begin
         wr(5'h01, {f[0], 6'h00, 1'b1, 2'h0});
         for (int c = 0; c < 8; c++) begin
            a2 = {c[0], c[2:0], c[2:0], c[2:0]};
            a3 = {c[1], c[2:0], c[2:0], ~c[2:0]};
            wr(5'h02, a2);
            wr(5'h03, a3);
            chk_dec(a2, a3, f[0]);
         end
      end
      wr(5'h02, 10'h3c7);
      wr(5'h03, 10'h2a5);
      rd(5'h03, d);
      check(d, 10'h2a5);
      wr(5'h01, 10'h200);
      check(config_active_o, 1'b0);
      check(config_crc_o, host.crc8(host.crc8(8'hff, {6'h00, 10'h3c7}), {6'h00, 10'h2a5}));
      chk_dec(10'h3c7, 10'h2a5, 1'b1);
      uv_case(1'b1);
      host.send(1'b1, 5'h01, 10'h204, 1'b1, r);
      tick(10);
      check(frame_error_o, 1'b1);
      check(config_active_o, 1'b0);
      rd(5'h02, d);
      check(d, 10'h3c7);
      check(frame_error_o, 1'b0);
      rd(5'h1f, d);
      check(d, 10'h000);
      final_report();
   end
endmodule
